/* rtl/sspc_pkg.sv */
// Package of constants for the soft skip PWM control block
package sspc_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int CLK_PERIOD_NS = 40;
   // Blanking window, a least time, rounded up
   localparam int MASK_TIME_NS = 250;
   localparam int MASK_CYCLES = (MASK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Light-load confirmation time
   localparam int CONFIRM_TIME_MS = 125;
   localparam int CONFIRM_CYCLES = CONFIRM_TIME_MS * (CLK_HZ / 1000);
   // Soft-start ramp duration
   localparam int RAMP_TIME_US = 2500;
   localparam int RAMP_CYCLES = RAMP_TIME_US * (CLK_HZ / 1000000);
   // Divider ratio, percentage and millivolt levels of the analog path
   localparam int FB_DIVIDE = 3;
   localparam int PEAK_LIMIT_MV = 1000;
   localparam int SKIP_PERCENT = 25;
   localparam int SKIP_LEVEL_MV = 750;
   localparam int SKIP_HYST_MV = 100;
   localparam int EXIT_LEVEL_MV = 1250;
   localparam int MV_W = 12;
   localparam logic [MV_W-1:0] PEAK_LIMIT = MV_W'(PEAK_LIMIT_MV);
   localparam logic [MV_W-1:0] SKIP_FLOOR = MV_W'(PEAK_LIMIT_MV * SKIP_PERCENT / 100);
   localparam logic [MV_W-1:0] SKIP_HI = MV_W'(SKIP_LEVEL_MV + SKIP_HYST_MV / 2);
   localparam logic [MV_W-1:0] SKIP_LO = MV_W'(SKIP_LEVEL_MV - SKIP_HYST_MV / 2);
   localparam logic [MV_W-1:0] EXIT_LEVEL = MV_W'(EXIT_LEVEL_MV);
   localparam int SYNC_STAGES = 2;
   typedef enum logic [1:0] {SSPC_NORMAL, SSPC_SKIP_IDLE, SSPC_SKIP_BURST} sspc_mode_e;
endpackage

/* rtl/sspc_sync.sv */
// Two-flop synchroniser bank for comparator and oscillator inputs
`timescale 1ns/1ps
module sspc_sync #(
   parameter int WIDTH = 1
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);
   import sspc_pkg::*;
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sspc_sync_s;
   sspc_sync_s st_q, st_d;
   // First stage feeds only the second
   always_comb begin
      st_d = st_q;
      st_d.meta = async_i;
      st_d.stable = st_q.meta;
   end
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign sync_o = st_q.stable;
endmodule

/* rtl/sspc_core.sv */
// Soft skip PWM latch, blanking, skip control and PFC supply switch control
`timescale 1ns/1ps
module sspc_core #(
   parameter int CONFIRM_CNT = sspc_pkg::CONFIRM_CYCLES,
   parameter int RAMP_CNT = sspc_pkg::RAMP_CYCLES,
   parameter int MASK_CNT = sspc_pkg::MASK_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic osc_clock_i,
   input wire logic [sspc_pkg::MV_W-1:0] feedback_level_i,
   input wire logic [sspc_pkg::MV_W-1:0] sense_mv_i,
   output logic drive_o,
   output logic pfc_supply_switch_o,
   output logic skip_mode_o,
   output logic [sspc_pkg::MV_W-1:0] peak_limit_o
);
   import sspc_pkg::*;
   localparam int CW = $clog2(CONFIRM_CNT + 1);
   localparam int RW = $clog2(RAMP_CNT + 1);
   localparam int MW = $clog2(MASK_CNT + 1);

   typedef struct packed {
      sspc_mode_e mode;
      logic osc_prev;
      logic drive;
      logic [MW-1:0] mask_cnt;
      logic [CW-1:0] confirm_cnt;
      logic [RW-1:0] ramp_cnt;
      logic pfc_on;
      logic [MV_W-1:0] limit;
      logic skip;
   } sspc_state_s;

   sspc_state_s st_q, st_d;
   logic osc_s;
   logic [MV_W-1:0] fb_s, cs_s;
   logic [MV_W-1:0] fb_div, ramp_lvl, eff_lvl;
   logic trip, light_load, above_exit, burst_on, burst_off;

   // Oscillator level crosses domains through the bank
   sspc_sync #(.WIDTH(1)) u_osc_sync (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i(osc_clock_i),
      .sync_o(osc_s)
   );
   // Multi-bit levels assumed slow versus the clock; a skew lasts one cycle
   sspc_sync #(.WIDTH(2*MV_W)) u_lvl_sync (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .async_i({feedback_level_i, sense_mv_i}),
      .sync_o({fb_s, cs_s})
   );

   // Scale function used for the feedback level path
   function automatic logic [MV_W-1:0] div3(input logic [MV_W-1:0] v);
      div3 = MV_W'(v / MV_W'(FB_DIVIDE));
   endfunction

   // Effective turn-off level: feedback/3, full-scale clamp, skip floor, ramp clamp
   always_comb begin
      fb_div = div3(fb_s);
      ramp_lvl = MV_W'((32'(st_q.ramp_cnt) * PEAK_LIMIT_MV) / RAMP_CNT);
      eff_lvl = fb_div;
      if (eff_lvl > PEAK_LIMIT) begin
         eff_lvl = PEAK_LIMIT;
      end
      if (eff_lvl < SKIP_FLOOR) begin
         eff_lvl = SKIP_FLOOR;
      end
      if (eff_lvl > ramp_lvl) begin
         eff_lvl = ramp_lvl;
      end
   end

   // Current-sense trip against the effective level; other comparators on the raw feedback pin level
   assign trip = (cs_s > eff_lvl) && (st_q.mask_cnt == '0);
   assign burst_off = fb_s < SKIP_LO;
   assign burst_on = fb_s > SKIP_HI;
   assign light_load = fb_s <= MV_W'(SKIP_LEVEL_MV);
   assign above_exit = fb_s > EXIT_LEVEL;

   always_comb begin
      st_d = st_q;
      st_d.osc_prev = osc_s;
      st_d.limit = eff_lvl;
      if (st_q.mask_cnt != '0) begin
         st_d.mask_cnt = st_q.mask_cnt - MW'(1);
      end
      if (st_q.ramp_cnt != RW'(RAMP_CNT)) begin
         st_d.ramp_cnt = st_q.ramp_cnt + RW'(1);
      end
      // Skip state machine
      unique case (st_q.mode)
         SSPC_NORMAL: begin
            if (burst_off) begin
               st_d.mode = SSPC_SKIP_IDLE;
            end
         end
         SSPC_SKIP_IDLE: begin
            if (above_exit) begin
               st_d.mode = SSPC_NORMAL;
            end else if (burst_on) begin
               st_d.mode = SSPC_SKIP_BURST;
               st_d.ramp_cnt = '0;
            end
         end
         SSPC_SKIP_BURST: begin
            if (above_exit) begin
               st_d.mode = SSPC_NORMAL;
            end else if (burst_off) begin
               st_d.mode = SSPC_SKIP_IDLE;
            end
         end
      endcase
      // PWM latch: set on oscillator rising edge, reset by trip
      if (st_d.mode == SSPC_SKIP_IDLE) begin
         st_d.drive = 1'b0;
      end else if (osc_s && !st_q.osc_prev) begin
         st_d.drive = 1'b1;
         st_d.mask_cnt = MW'(MASK_CNT);
      end else if (st_q.drive && trip) begin
         st_d.drive = 1'b0;
      end
      // Light-load confirmation timer and PFC supply switch
      if (above_exit) begin
         st_d.confirm_cnt = '0;
         st_d.pfc_on = 1'b1;
      end else if (!light_load && st_q.pfc_on) begin
         st_d.confirm_cnt = '0;
      end else if (light_load && st_q.pfc_on) begin
         if (st_q.confirm_cnt == CW'(CONFIRM_CNT - 1)) begin
            st_d.pfc_on = 1'b0;
            st_d.confirm_cnt = '0;
         end else begin
            st_d.confirm_cnt = st_q.confirm_cnt + CW'(1);
         end
      end else begin
         // Open switch held below the exit level; ripple cannot close it
         st_d.pfc_on = st_q.pfc_on;
      end
      // Skip flag registered so the output pin comes from a flop
      st_d.skip = (st_d.mode != SSPC_NORMAL);
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         st_q.mode <= SSPC_NORMAL;
         st_q.osc_prev <= 1'b0;
         st_q.drive <= 1'b0;
         st_q.mask_cnt <= '0;
         st_q.confirm_cnt <= '0;
         st_q.ramp_cnt <= '0; // Power-up soft start
         st_q.pfc_on <= 1'b1;
         st_q.limit <= '0;
         st_q.skip <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   assign drive_o = st_q.drive;
   assign pfc_supply_switch_o = st_q.pfc_on;
   assign skip_mode_o = st_q.skip;
   assign peak_limit_o = st_q.limit;

   // Assertions
   a_drive_blanked: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(st_q.drive) |=> st_q.drive [*2]) else $error("drive ended inside blanking");
   a_idle_no_drive: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q.mode == SSPC_SKIP_IDLE) |-> !st_q.drive) else $error("drive during skip idle");
   a_exit_closes: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      above_exit |=> st_q.pfc_on && st_q.mode == SSPC_NORMAL) else $error("exit did not close switch");
   a_open_held: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!st_q.pfc_on && !above_exit) |=> !st_q.pfc_on) else $error("switch closed below exit level");
   a_burst_ramp: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q.mode == SSPC_SKIP_IDLE && st_d.mode == SSPC_SKIP_BURST) |=> st_q.ramp_cnt == '0)
      else $error("burst without ramp restart");
   a_limit_clamp: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      st_q.limit <= PEAK_LIMIT) else $error("limit above full scale");
   a_trip_off: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q.drive && trip && !(osc_s && !st_q.osc_prev)) |=> !st_q.drive) else $error("trip ignored");
   a_timer_open: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $fell(st_q.pfc_on) |-> $past(light_load)) else $error("switch opened without light load");
   a_fast_stop: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q.mode == SSPC_SKIP_BURST && burst_off && !above_exit) |=> !st_q.drive)
      else $error("burst not stopped");

   // Skip flag must track the mode register exactly
   a_skip_flag: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      st_q.skip == (st_q.mode != SSPC_NORMAL)) else $error("skip flag out of step");

   // A finished ramp never lets the level drop under the skip floor
   a_limit_floor: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q.ramp_cnt == RW'(RAMP_CNT)) |=> st_q.limit >= SKIP_FLOOR) else $error("limit under floor");

   // Ramp climbs one step per clock unless a burst restarts it
   a_ramp_step: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (st_q.ramp_cnt != RW'(RAMP_CNT) && !(st_q.mode == SSPC_SKIP_IDLE && st_d.mode == SSPC_SKIP_BURST))
      |=> st_q.ramp_cnt == $past(st_q.ramp_cnt) + RW'(1)) else $error("ramp step wrong");

   // Each turn-on loads the full blanking count
   a_mask_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(st_q.drive) |-> st_q.mask_cnt == MW'(MASK_CNT)) else $error("blanking not loaded");

   // Turn-on only follows an oscillator edge
   a_drive_rise: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(st_q.drive) |-> $past(osc_s && !st_q.osc_prev)) else $error("drive rose without cycle start");

   // Early release of light load clears the confirmation timer
   a_confirm_clear: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      (!light_load && st_q.pfc_on) |=> st_q.confirm_cnt == '0) else $error("timer not cleared");

   // Switch only closes again through the exit level
   a_close_exit: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
      $rose(st_q.pfc_on) |-> $past(above_exit)) else $error("switch closed without exit");
endmodule

/* verif/sspc_gate_model.sv */
// Power switch and sense resistor model seen from the drive pin
`timescale 1ns/1ps
module sspc_gate_model (
   input wire logic sys_clk_i,
   input wire logic drive_i,
   input wire logic [11:0] slope_i,
   output logic [11:0] sense_mv_o
);
   int on_cnt = 0;
   // Time on since turn-on; a slope of a few mV makes a slow supply
   always @(posedge sys_clk_i) begin
      on_cnt <= drive_i ? on_cnt + 1 : 0;
   end
   // Spike of 2 V for three clocks, then a ramp; no current while off
   assign sense_mv_o = !drive_i ? 12'h000 : (on_cnt < 3) ? 12'h7D0 : 12'(on_cnt * slope_i);
endmodule

/* verif/soft_skip_pwm_control_tb_top.sv */
// Self-checking bench for the soft skip PWM control core
`timescale 1ns/1ps
module soft_skip_pwm_control_tb_top;
   import sspc_pkg::*;
   logic clk = 0, rst = 1, osc = 0, drv, sw, skip;
   logic [MV_W-1:0] fb = 12'hBB8, sense, lim, slope = 12'h03C;
   int n_fail = 0, cmp_count = 0, osc_cnt = 0, n, f;
   int corner[4] = '{1251, 2999, 3000, 4095};
   bit [31:0] seed = 32'h0000002E;
   always #20 clk = ~clk;
   // Oscillator of 40 clocks with a short high phase
   always @(negedge clk) begin
      osc_cnt <= (osc_cnt == 39) ? 0 : osc_cnt + 1;
      osc <= (osc_cnt < 4);
   end
   // Short counts keep the light-load and ramp phases brief
   sspc_core #(.CONFIRM_CNT(50), .RAMP_CNT(20), .MASK_CNT(7)) sspc_core_i (.sys_clk_i(clk), .sys_rst_i(rst),
      .osc_clock_i(osc), .feedback_level_i(fb), .sense_mv_i(sense), .drive_o(drv), .pfc_supply_switch_o(sw),
      .skip_mode_o(skip), .peak_limit_o(lim));
   sspc_gate_model sspc_gate_model_i (.sys_clk_i(clk), .drive_i(drv), .slope_i(slope), .sense_mv_o(sense));
   // Helpers: random source, expected level, compares and bounded waits
   function automatic bit [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [MV_W-1:0] exp_lim(int v);
      v = v / 3;
      v = (v > 1000) ? 1000 : (v < 250) ? 250 : v;
      return MV_W'(v);
   endfunction
   function automatic logic pick(int k);
      return (k == 0) ? drv : (k == 1) ? sw : skip;
   endfunction
   task automatic wrap_up();
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk_v(logic [MV_W-1:0] got, logic [MV_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_b(logic got, logic exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(int c);
      repeat (c) @(negedge clk);
   endtask
   // A wait that runs out counts as a mismatch and ends the run
   task automatic wait_sig(int k, logic v, int max);
      for (int i = 0; i < max; i++) begin
         if (pick(k) === v) return;
         @(negedge clk);
      end
      n_fail++;
      wrap_up();
   endtask
   task automatic count_high(int c, output int m);
      m = 0;
      repeat (c) begin
         @(negedge clk);
         m += (drv === 1'b1);
      end
   endtask
   // Main sequence: reset, levels, pulses, light load, skip entry and exit
   initial begin
      cyc(11);
      chk_b(drv, 1'b0);
      chk_b(sw, 1'b1);
      chk_v(lim, 12'h000);
      cyc(1);
      rst = 0;
      cyc(5);
      chk_b(lim < 12'h3E8, 1'b1);
      cyc(30);
      chk_v(lim, 12'h3E8);
      for (int i = 0; i < 10; i++) begin
         f = (i < 4) ? corner[i] : 1260 + int'(xs() % 2800);
         fb = MV_W'(f);
         cyc(6);
         chk_v(lim, exp_lim(f));
      end
      fb = 12'hBB8;
      repeat (3) begin
         slope = MV_W'(40 + xs() % 21);
         wait_sig(0, 1'b1, 50);
         n = 0;
         while (drv === 1'b1 && n < 50) begin
            cyc(1);
            n++;
         end
         chk_b(n > 7 && n < 40, 1'b1);
         count_high(8, n);
         chk_v(MV_W'(n), 12'h000);
      end
      // Light load interrupted once, then held to expiry
      fb = 12'h2D0;
      cyc(6);
      chk_v(lim, exp_lim(720));
      cyc(34);
      fb = 12'h384;
      cyc(5);
      fb = 12'h2D0;
      cyc(45);
      chk_b(sw, 1'b1);
      wait_sig(1, 1'b0, 20);
      fb = 12'h514;
      wait_sig(1, 1'b1, 6);
      fb = 12'h258;
      wait_sig(2, 1'b1, 6);
      count_high(80, n);
      chk_v(MV_W'(n), 12'h000);
      chk_b(sw, 1'b0);
      fb = 12'h30C;
      count_high(80, n);
      chk_v(MV_W'(n), 12'h000);
      fb = 12'h4B0;
      cyc(6);
      chk_b(lim < 12'h190, 1'b1);
      cyc(30);
      chk_v(lim, exp_lim(1200));
      count_high(80, n);
      chk_b(n > 0, 1'b1);
      chk_b(sw, 1'b0);
      wait_sig(0, 1'b1, 50);
      fb = 12'h258;
      cyc(5);
      chk_b(drv, 1'b0);
      fb = 12'h514;
      cyc(5);
      chk_b(sw, 1'b1);
      chk_b(skip, 1'b0);
      count_high(80, n);
      chk_b(n > 0, 1'b1);
      wrap_up();
   end
endmodule
